// [core/qfr_read_engine.sv]
`timescale 1ns/1ps
module qfr_read_engine (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	// flash pins
	input wire logic flash_cs_n_in,
	input wire logic flash_sclk_in,
	input wire logic [3:0] io_line_in,
	output logic [3:0] io_line_out,
	output logic [3:0] io_line_oe_out,
	// configuration and status bits
	input wire logic quad_enable_bit_in,
	input wire logic array_busy_in,
	input wire logic four_wire_command_mode_in,
	input wire logic set_read_param_in,
	input wire logic [1:0] read_param_in,
	input wire logic reset_instr_in,
	input wire logic cont_mode_reset_in,
	output logic cont_mode_out,
	output logic wrap_disabled_out,
	output logic [1:0] wrap_len_out,
	output logic [3:0] dummy_clocks_out,
	// array read stream
	output logic [23:0] mem_addr_out,
	output logic mem_ready_out,
	input wire logic mem_valid_in,
	input wire logic [7:0] mem_data_in
);
	qfr_buf_if buf_bus ();
	logic [5:0] pins_lvl;
	logic cs_n_lvl, sclk_lvl;
	logic [3:0] io_lvl;
	logic sclk_prev_reg, cs_prev_reg;
	logic rise, fall, cs_fall, cs_rise, in_evt, out_evt, accept;
	qfr_pkg::qfr_state_t state_reg, state_next;
	qfr_pkg::qfr_cmd_t cmd_reg, cmd_next;
	logic [5:0] cnt_reg, cnt_next;
	logic [23:0] shift_reg, shift_next, smp;
	logic dtr_reg, dtr_next, wide_reg, wide_next;
	logic cont_reg, cont_next;
	logic wrap_dis_reg, wrap_dis_next;
	logic [1:0] wrap_len_reg, wrap_len_next;
	logic [3:0] dummy_cfg_reg, dummy_cfg_next;
	logic [23:0] addr_reg, addr_next;
	logic fetch_reg, fetch_next, wrap_on_reg, wrap_on_next;
	logic [3:0] io_out_reg, io_out_next, io_oe_reg, io_oe_next;
	logic [3:0] low_nib_reg, low_nib_next;
	logic nib_sel_reg, nib_sel_next, pop;
	logic [5:0] dly;
	logic is_quad_op, addr_done;

	// three-stage filter on every pin; sclk is sampled, not used as a clock
	qfr_sync #(.WIDTH(6)) u_sync (
		.clk_sys_in(clk_sys_in),
		.rst_n_in(rst_n_in),
		.raw_in({flash_cs_n_in, flash_sclk_in, io_line_in}),
		.level_out(pins_lvl)
	);

	// two bytes of slack so a late pop never drops an array word
	qfr_skid_buffer u_buf (
		.clk_sys_in(clk_sys_in),
		.rst_n_in(rst_n_in),
		.bus(buf_bus.store)
	);

	// four-wire dummy field decode
	function automatic logic [3:0] dummy_of(input logic [1:0] p);
		unique case (p)
			2'h0: dummy_of = qfr_pkg::DUMMY_P00;
			2'h1: dummy_of = qfr_pkg::DUMMY_P01;
			2'h2: dummy_of = qfr_pkg::DUMMY_P10;
			2'h3: dummy_of = qfr_pkg::DUMMY_P11;
		endcase
	endfunction : dummy_of

	// address step, circling inside the aligned section when wrapping
	function automatic logic [23:0] next_addr(input logic [23:0] a,
		input logic wrap, input logic [1:0] len);
		logic [23:0] inc;
		logic [23:0] mask;
		inc = a + 24'h000001;
		mask = (qfr_pkg::WRAP_UNIT << len) - 24'h000001;
		next_addr = wrap ? ((a & ~mask) | (inc & mask)) : inc;
	endfunction : next_addr

	// pin edges as seen from the system clock
	assign {cs_n_lvl, sclk_lvl, io_lvl} = pins_lvl;
	assign rise = sclk_lvl & ~sclk_prev_reg;
	assign fall = ~sclk_lvl & sclk_prev_reg;
	assign cs_fall = ~cs_n_lvl & cs_prev_reg;
	assign cs_rise = cs_n_lvl & ~cs_prev_reg;
	assign in_evt = rise | (dtr_reg & fall);
	assign out_evt = fall | (dtr_reg & rise);
	assign accept = mem_valid_in & buf_bus.in_ready;
	assign smp = wide_reg ? {shift_reg[19:0], io_lvl}
		: {shift_reg[22:0], io_lvl[0]};
	assign is_quad_op = smp[7:0] == qfr_pkg::OP_QUAD_OUTPUT_READ
		|| smp[7:0] == qfr_pkg::OP_QUAD_IO_READ
		|| smp[7:0] == qfr_pkg::OP_DOUBLE_RATE_QUAD_IO_READ;
	assign addr_done = state_reg == qfr_pkg::ST_ADDR && in_evt
		&& cnt_reg == 6'h01 && !cs_rise;
	assign buf_bus.in_valid = mem_valid_in;
	assign buf_bus.in_data = mem_data_in;
	assign buf_bus.out_ready = pop;
	assign buf_bus.flush = ~fetch_reg;

	// settings, frame sequencer, fetch pointer and data shifter
	always_comb begin
		state_next = state_reg;
		cmd_next = cmd_reg;
		cnt_next = cnt_reg;
		shift_next = shift_reg;
		dtr_next = dtr_reg;
		wide_next = wide_reg;
		cont_next = cont_reg;
		wrap_dis_next = wrap_dis_reg;
		wrap_len_next = wrap_len_reg;
		dummy_cfg_next = dummy_cfg_reg;
		addr_next = addr_reg;
		fetch_next = fetch_reg;
		wrap_on_next = wrap_on_reg;
		io_out_next = io_out_reg;
		io_oe_next = io_oe_reg;
		low_nib_next = low_nib_reg;
		nib_sel_next = nib_sel_reg;
		pop = 1'b0;
		dly = qfr_pkg::QIO_DUMMY_CLKS;
		// continuation and dummy clears go first so a captured mode key still wins; wrap defaults go last
		if (set_read_param_in) dummy_cfg_next = dummy_of(read_param_in);
		if (reset_instr_in) begin
			dummy_cfg_next = qfr_pkg::DUMMY_CFG_RESET;
			cont_next = 1'b0;
		end
		if (cont_mode_reset_in) cont_next = 1'b0;
		if (accept) addr_next = next_addr(addr_reg, wrap_on_reg, wrap_len_reg);
		unique case (state_reg)
			qfr_pkg::ST_IDLE: begin
				if (cs_fall) begin
					shift_next = 24'h000000;
					if (array_busy_in) begin
						state_next = qfr_pkg::ST_IGNORE;
					end else if (cont_reg) begin
						state_next = qfr_pkg::ST_ADDR;
						wide_next = 1'b1;
						cnt_next = qfr_pkg::ADDR_NIBBLES;
					end else begin
						state_next = qfr_pkg::ST_OPCODE;
						dtr_next = 1'b0;
						wide_next = four_wire_command_mode_in;
						cnt_next = four_wire_command_mode_in
							? qfr_pkg::OPCODE_NIBBLES : qfr_pkg::OPCODE_BITS;
					end
				end
			end
			qfr_pkg::ST_OPCODE: begin
				if (rise) begin
					shift_next = smp;
					cnt_next = cnt_reg - 6'h01;
					if (cnt_reg == 6'h01) begin
						state_next = qfr_pkg::ST_ADDR;
						cnt_next = qfr_pkg::ADDR_NIBBLES;
						wide_next = 1'b1;
						if (is_quad_op && !quad_enable_bit_in) begin
							state_next = qfr_pkg::ST_IGNORE;
						end else if (smp[7:0] == qfr_pkg::OP_QUAD_OUTPUT_READ) begin
							cmd_next = qfr_pkg::CMD_QOR;
							wide_next = four_wire_command_mode_in;
							if (!four_wire_command_mode_in) cnt_next = qfr_pkg::ADDR_SERIAL_BITS;
						end else if (smp[7:0] == qfr_pkg::OP_QUAD_IO_READ) begin
							cmd_next = qfr_pkg::CMD_QIO;
						end else if (smp[7:0] == qfr_pkg::OP_DOUBLE_RATE_QUAD_IO_READ) begin
							cmd_next = qfr_pkg::CMD_DTR;
							dtr_next = 1'b1;
							// the fall closing the opcode clock is shifted out unused
							cnt_next = qfr_pkg::ADDR_NIBBLES + 6'h01;
						end else if (smp[7:0] == qfr_pkg::OP_BURST_WRAP_SETUP) begin
							state_next = qfr_pkg::ST_WRAPSET;
							wide_next = four_wire_command_mode_in;
							cnt_next = four_wire_command_mode_in
								? qfr_pkg::WRAP_FRAME_NIBBLES : qfr_pkg::WRAP_FRAME_BITS;
						end else begin
							state_next = qfr_pkg::ST_IGNORE;
						end
					end
				end
			end
			qfr_pkg::ST_ADDR: begin
				if (in_evt) begin
					shift_next = smp;
					cnt_next = cnt_reg - 6'h01;
					if (cnt_reg == 6'h01) begin
						addr_next = smp;
						fetch_next = 1'b1;
						// wrap only for quad I/O reads outside four-wire mode
						wrap_on_next = cmd_reg != qfr_pkg::CMD_QOR
							&& !four_wire_command_mode_in && !wrap_dis_reg;
						state_next = qfr_pkg::ST_MODE;
						cnt_next = qfr_pkg::MODE_NIBBLES;
						if (cmd_reg == qfr_pkg::CMD_QOR) begin
							state_next = qfr_pkg::ST_DUMMY;
							cnt_next = qfr_pkg::QOR_DUMMY_CLKS;
						end
					end
				end
			end
			qfr_pkg::ST_MODE: begin
				if (four_wire_command_mode_in) begin
					dly = {2'h0, dummy_cfg_reg - qfr_pkg::MODE_CLKS};
				end else if (dtr_reg) begin
					dly = qfr_pkg::DTR_DUMMY_CLKS;
				end
				if (in_evt) begin
					cnt_next = cnt_reg - 6'h01;
					// upper nibble carries mode bits 7:4; lower nibble is don't care
					if (cnt_reg == qfr_pkg::MODE_NIBBLES) begin
						cont_next = io_lvl[qfr_pkg::CONT_KEY_LSB +: 2]
							== qfr_pkg::CONT_MODE_KEY;
					end
					if (cnt_reg == 6'h01) begin
						state_next = (dly == 6'h00) ? qfr_pkg::ST_DATA : qfr_pkg::ST_DUMMY;
						cnt_next = dly;
						nib_sel_next = 1'b0;
					end
				end
			end
			qfr_pkg::ST_DUMMY: begin
				if (rise) begin
					cnt_next = cnt_reg - 6'h01;
					if (cnt_reg == 6'h01) begin
						state_next = qfr_pkg::ST_DATA;
						nib_sel_next = 1'b0;
					end
				end
			end
			qfr_pkg::ST_DATA: begin
				// high nibble first; an empty buffer repeats the last nibble
				if (out_evt) begin
					if (!nib_sel_reg) begin
						if (buf_bus.out_valid) begin
							io_out_next = buf_bus.out_data[7:4];
							low_nib_next = buf_bus.out_data[3:0];
							io_oe_next = 4'hF;
							pop = 1'b1;
							nib_sel_next = 1'b1;
						end
					end else begin
						io_out_next = low_nib_reg;
						nib_sel_next = 1'b0;
					end
				end
			end
			qfr_pkg::ST_WRAPSET: begin
				if (rise) begin
					shift_next = smp;
					cnt_next = cnt_reg - 6'h01;
					// a frame cut short never touches the wrap setting
					if (cnt_reg == 6'h01) begin
						wrap_dis_next = smp[qfr_pkg::WRAP_DIS_BIT];
						wrap_len_next = smp[qfr_pkg::WRAP_LEN_LSB +: 2];
						state_next = qfr_pkg::ST_IGNORE;
					end
				end
			end
			qfr_pkg::ST_IGNORE: begin
				state_next = qfr_pkg::ST_IGNORE;
			end
			default: begin
				state_next = qfr_pkg::ST_IDLE;
			end
		endcase
		if (cs_rise) begin
			state_next = qfr_pkg::ST_IDLE;
			io_oe_next = 4'h0;
			fetch_next = 1'b0;
			wrap_on_next = 1'b0;
		end
		if (reset_instr_in) begin
			wrap_dis_next = qfr_pkg::WRAP_DIS_RESET;
			wrap_len_next = qfr_pkg::WRAP_LEN_RESET;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sclk_prev_reg <= 1'b1;
			cs_prev_reg <= 1'b1;
			state_reg <= qfr_pkg::ST_IDLE;
			cmd_reg <= qfr_pkg::CMD_QIO;
			cnt_reg <= 6'h00;
			shift_reg <= 24'h000000;
			dtr_reg <= 1'b0;
			wide_reg <= 1'b0;
			cont_reg <= 1'b0;
			wrap_dis_reg <= qfr_pkg::WRAP_DIS_RESET;
			wrap_len_reg <= qfr_pkg::WRAP_LEN_RESET;
			dummy_cfg_reg <= qfr_pkg::DUMMY_CFG_RESET;
			addr_reg <= qfr_pkg::ADDR_RESET;
			fetch_reg <= 1'b0;
			wrap_on_reg <= 1'b0;
			io_out_reg <= 4'h0;
			io_oe_reg <= 4'h0;
			low_nib_reg <= 4'h0;
			nib_sel_reg <= 1'b0;
		end else begin
			sclk_prev_reg <= sclk_lvl;
			cs_prev_reg <= cs_n_lvl;
			state_reg <= state_next;
			cmd_reg <= cmd_next;
			cnt_reg <= cnt_next;
			shift_reg <= shift_next;
			dtr_reg <= dtr_next;
			wide_reg <= wide_next;
			cont_reg <= cont_next;
			wrap_dis_reg <= wrap_dis_next;
			wrap_len_reg <= wrap_len_next;
			dummy_cfg_reg <= dummy_cfg_next;
			addr_reg <= addr_next;
			fetch_reg <= fetch_next;
			wrap_on_reg <= wrap_on_next;
			io_out_reg <= io_out_next;
			io_oe_reg <= io_oe_next;
			low_nib_reg <= low_nib_next;
			nib_sel_reg <= nib_sel_next;
		end
	end

	// outputs straight from flops
	assign io_line_out = io_out_reg;
	assign io_line_oe_out = io_oe_reg;
	assign cont_mode_out = cont_reg;
	assign wrap_disabled_out = wrap_dis_reg;
	assign wrap_len_out = wrap_len_reg;
	assign dummy_clocks_out = dummy_cfg_reg;
	assign mem_addr_out = addr_reg;
	assign mem_ready_out = buf_bus.in_ready;

	// checks on the sequencer
	AST_CS_RELEASE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		cs_rise |=> io_line_oe_out == 4'h0 ##1 io_line_oe_out == 4'h0)
		else $error("data lines still driven after chip select rose");
	AST_BUSY_REJECT: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		(state_reg == qfr_pkg::ST_IDLE && cs_fall && array_busy_in)
		|=> state_reg == qfr_pkg::ST_IGNORE)
		else $error("read accepted while array busy");
	AST_QE_GATE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		(state_reg == qfr_pkg::ST_OPCODE && rise && cnt_reg == 6'h01 && !cs_rise
		&& is_quad_op && !quad_enable_bit_in) |=> state_reg == qfr_pkg::ST_IGNORE)
		else $error("quad read taken without quad enable");
	AST_ADDR_STEP: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		(accept && !wrap_on_reg && !addr_done)
		|=> mem_addr_out == $past(mem_addr_out) + 24'h000001)
		else $error("read address did not step by one");
	AST_WRAP_PAGE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		(accept && wrap_on_reg) |=> mem_addr_out[23:6] == $past(mem_addr_out[23:6]))
		else $error("wrapped read left its section");
	AST_CONT_KEY: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		(state_reg == qfr_pkg::ST_MODE && in_evt && cnt_reg == qfr_pkg::MODE_NIBBLES
		&& io_lvl[1:0] == 2'h2) |=> cont_mode_out)
		else $error("continuation key not captured");
	AST_DUMMY_DEFAULT: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		reset_instr_in |=> dummy_clocks_out == 4'h2)
		else $error("dummy count not back to two");
	AST_DUMMY_MAP: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		(set_read_param_in && !reset_instr_in && read_param_in == 2'h0)
		|=> dummy_clocks_out == 4'hA)
		else $error("dummy field 00 not mapped to ten");
	AST_FALL_DRIVE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		(!dtr_reg && $changed(io_line_out)) |-> $past(fall))
		else $error("single-rate data changed off a falling edge");
	AST_NO_WRAP_QPI: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		(addr_done && four_wire_command_mode_in) |=> !wrap_on_reg)
		else $error("wrap armed in four-wire mode");
endmodule : qfr_read_engine

// [core/qfr_pkg.sv]
package qfr_pkg;
	// command codes; the quad-output read code is a plain default
	localparam logic [7:0] OP_QUAD_OUTPUT_READ = 8'h6B;
	localparam logic [7:0] OP_QUAD_IO_READ = 8'hEB;
	localparam logic [7:0] OP_DOUBLE_RATE_QUAD_IO_READ = 8'hED;
	localparam logic [7:0] OP_BURST_WRAP_SETUP = 8'h77;
	// phase lengths in samples (bits, nibbles or clocks)
	localparam logic [5:0] OPCODE_BITS = 6'h08;
	localparam logic [5:0] OPCODE_NIBBLES = 6'h02;
	localparam logic [5:0] ADDR_SERIAL_BITS = 6'h18;
	localparam logic [5:0] ADDR_NIBBLES = 6'h06;
	localparam logic [5:0] QOR_DUMMY_CLKS = 6'h08;
	localparam logic [5:0] MODE_NIBBLES = 6'h02;
	localparam logic [5:0] QIO_DUMMY_CLKS = 6'h04;
	localparam logic [5:0] DTR_DUMMY_CLKS = 6'h04;
	localparam logic [5:0] WRAP_FRAME_BITS = 6'h20;
	localparam logic [5:0] WRAP_FRAME_NIBBLES = 6'h08;
	// four-wire dummy settings
	localparam logic [3:0] DUMMY_CFG_RESET = 4'h2;
	localparam logic [3:0] DUMMY_P00 = 4'hA;
	localparam logic [3:0] DUMMY_P01 = 4'h4;
	localparam logic [3:0] DUMMY_P10 = 4'h6;
	localparam logic [3:0] DUMMY_P11 = 4'h8;
	localparam logic [3:0] MODE_CLKS = 4'h2;
	// mode and wrap field layout
	localparam logic [1:0] CONT_MODE_KEY = 2'h2;
	localparam int CONT_KEY_LSB = 0;
	localparam int WRAP_DIS_BIT = 4;
	localparam int WRAP_LEN_LSB = 5;
	localparam logic WRAP_DIS_RESET = 1'b1;
	localparam logic [1:0] WRAP_LEN_RESET = 2'h0;
	localparam logic [23:0] ADDR_RESET = 24'h000000;
	localparam logic [23:0] WRAP_UNIT = 24'h000008;
	localparam logic [1:0] BUF_DEPTH = 2'h2;
	typedef enum logic [7:0] {
		ST_IDLE = 8'h01, ST_OPCODE = 8'h02, ST_ADDR = 8'h04, ST_MODE = 8'h08,
		ST_DUMMY = 8'h10, ST_DATA = 8'h20, ST_WRAPSET = 8'h40,
		ST_IGNORE = 8'h80
	} qfr_state_t;
	typedef enum logic [2:0] {
		CMD_QOR = 3'h1, CMD_QIO = 3'h2, CMD_DTR = 3'h4
	} qfr_cmd_t;
endpackage : qfr_pkg

// [core/qfr_buf_if.sv]
`timescale 1ns/1ps
interface qfr_buf_if;
	logic in_valid;
	logic in_ready;
	logic [7:0] in_data;
	logic out_valid;
	logic out_ready;
	logic [7:0] out_data;
	logic flush;
	modport store (input in_valid, in_data, out_ready, flush,
		output in_ready, out_valid, out_data);
	modport user (output in_valid, in_data, out_ready, flush,
		input in_ready, out_valid, out_data);
endinterface : qfr_buf_if

// [core/qfr_sync.sv]
`timescale 1ns/1ps
module qfr_sync #(
	parameter int WIDTH = 6
) (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	// raw pins and filtered levels
	input wire logic [WIDTH-1:0] raw_in,
	output logic [WIDTH-1:0] level_out
);
	logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, lvl_reg;
	logic [WIDTH-1:0] lvl_next;

	// a bit moves only once the second and third stages agree
	always_comb begin
		lvl_next = (lvl_reg & (s2_reg ^ s3_reg)) | (s2_reg & ~(s2_reg ^ s3_reg));
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s1_reg <= '1;
			s2_reg <= '1;
			s3_reg <= '1;
			lvl_reg <= '1;
		end else begin
			s1_reg <= raw_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			lvl_reg <= lvl_next;
		end
	end

	assign level_out = lvl_reg;
endmodule : qfr_sync

// [core/qfr_skid_buffer.sv]
`timescale 1ns/1ps
module qfr_skid_buffer (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	// both sides of the buffer
	qfr_buf_if.store bus
);
	logic [7:0] head_reg, tail_reg, head_next, tail_next;
	logic [1:0] count_reg, count_next;
	logic in_ready_reg, in_ready_next;
	logic push, pop;

	// head always holds the oldest byte; ready is registered
	always_comb begin
		push = bus.in_valid & in_ready_reg;
		pop = bus.out_ready & (count_reg != 2'h0);
		head_next = head_reg;
		tail_next = tail_reg;
		count_next = count_reg;
		if (push && !pop) begin
			if (count_reg == 2'h0) head_next = bus.in_data;
			else tail_next = bus.in_data;
			count_next = count_reg + 2'h1;
		end else if (pop && !push) begin
			head_next = tail_reg;
			count_next = count_reg - 2'h1;
		end else if (push && pop) begin
			if (count_reg == 2'h1) begin
				head_next = bus.in_data;
			end else begin
				head_next = tail_reg;
				tail_next = bus.in_data;
			end
		end
		if (bus.flush) count_next = 2'h0;
		in_ready_next = !bus.flush && (count_next != qfr_pkg::BUF_DEPTH);
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			head_reg <= 8'h00;
			tail_reg <= 8'h00;
			count_reg <= 2'h0;
			in_ready_reg <= 1'b0;
		end else begin
			head_reg <= head_next;
			tail_reg <= tail_next;
			count_reg <= count_next;
			in_ready_reg <= in_ready_next;
		end
	end

	assign bus.in_ready = in_ready_reg;
	assign bus.out_valid = count_reg != 2'h0;
	assign bus.out_data = head_reg;
endmodule : qfr_skid_buffer

// [test/qfr_host_model.sv]
`timescale 1ns/1ps
module qfr_host_model (
	// clock
	input wire logic clk_sys_in,
	// host side of the flash pins
	output logic cs_n_out,
	output logic sclk_out,
	output logic drive_out,
	output logic [3:0] val_out,
	input wire logic [3:0] io_seen_in
);
	// idle pins: deselected, clock parked low, lines released
	initial begin
		cs_n_out = 1'b1;
		sclk_out = 1'b0;
		drive_out = 1'b0;
		val_out = 4'h0;
	end
	// one serial clock; reading late in the high half gives the filter time
	task automatic tick(input logic [3:0] v, input logic drv,
		output logic [3:0] got);
		drive_out = drv;
		val_out = v;
		repeat (4) @(negedge clk_sys_in);
		sclk_out = 1'b1;
		repeat (4) @(negedge clk_sys_in);
		got = io_seen_in;
		sclk_out = 1'b0;
	endtask : tick
	// half a serial clock for double-rate phases; the line is read first
	task automatic half(input logic [3:0] v, input logic drv,
		output logic [3:0] got);
		repeat (2) @(negedge clk_sys_in);
		drive_out = drv;
		val_out = v;
		repeat (2) @(negedge clk_sys_in);
		got = io_seen_in;
		sclk_out = ~sclk_out;
	endtask : half
	// n units msb first, one bit on line 0 or a nibble on all lines
	task automatic send(input logic [31:0] v, input int n, input int w);
		logic [3:0] g;
		for (int i = n - 1; i >= 0; i--) begin
			if (w == 1)
				tick({3'h0, v[i]}, 1'b1, g);
			else
				tick(v[i*4 +: 4], 1'b1, g);
		end
	endtask : send
	// dummy clocks with the lines released before data comes back
	task automatic idle(input int n);
		logic [3:0] g;
		for (int i = 0; i < n; i++)
			tick(4'h0, 1'b0, g);
	endtask : idle
	// one byte, high nibble first
	task automatic rd_byte(output logic [7:0] b);
		tick(4'h0, 1'b0, b[7:4]);
		tick(4'h0, 1'b0, b[3:0]);
	endtask : rd_byte
	task automatic open;
		cs_n_out = 1'b0;
		repeat (3) @(negedge clk_sys_in);
	endtask : open
	// chip select may rise anywhere in the data phase
	task automatic close;
		cs_n_out = 1'b1;
		drive_out = 1'b0;
		repeat (10) @(negedge clk_sys_in);
	endtask : close
endmodule : qfr_host_model

// [test/tb_qfr_read_engine.sv]
`timescale 1ns/1ps
module tb_qfr_read_engine;
	logic clk_sys_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic qe = 1'b1, busy = 1'b0, fw = 1'b0, set_rp = 1'b0;
	logic rst_ins = 1'b0, cmr = 1'b0;
	logic [1:0] rp = 2'h0;
	logic cs_n, sclk, drv, cont, wdis, mrdy;
	logic [3:0] hval, io_in, io_out, io_oe, dclk;
	logic [1:0] wlen;
	logic [23:0] maddr;
	int errors = 0, samples_checked = 0, cycles = 0;
	// 25 MHz system clock
	always #20 clk_sys_in = ~clk_sys_in;
	// a released line shows the inverse of the value the host now puts on hval
	assign io_in = (io_oe & io_out) | (~io_oe & (drv ? hval : ~hval));
	qfr_host_model host (.clk_sys_in(clk_sys_in), .cs_n_out(cs_n),
		.sclk_out(sclk), .drive_out(drv), .val_out(hval),
		.io_seen_in(io_out));
	// array answers every cycle with a byte derived from its address
	qfr_read_engine dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
		.flash_cs_n_in(cs_n), .flash_sclk_in(sclk), .io_line_in(io_in),
		.io_line_out(io_out), .io_line_oe_out(io_oe),
		.quad_enable_bit_in(qe), .array_busy_in(busy),
		.four_wire_command_mode_in(fw), .set_read_param_in(set_rp),
		.read_param_in(rp), .reset_instr_in(rst_ins),
		.cont_mode_reset_in(cmr), .cont_mode_out(cont),
		.wrap_disabled_out(wdis), .wrap_len_out(wlen),
		.dummy_clocks_out(dclk), .mem_addr_out(maddr),
		.mem_ready_out(mrdy), .mem_valid_in(1'b1),
		.mem_data_in(maddr[7:0] ^ maddr[23:16]));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic conclude;
		$display("errors=%0d samples_checked=%0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : conclude
	// quad I/O read header; nd is the dummy count after the mode clocks
	task automatic qio(input logic [23:0] a, input logic [7:0] m,
		input logic op, input int nd);
		host.open();
		if (op)
			host.send({24'h0, qfr_pkg::OP_QUAD_IO_READ},
				fw ? 2 : 8, fw ? 4 : 1);
		host.send({8'h0, a}, 6, 4);
		host.send({24'h0, m}, 2, 4);
		host.idle(nd);
	endtask : qio
	// n bytes compared; sec is the wrap section size, 0 for none
	task automatic rd_chk(input logic [23:0] a, input int n,
		input logic [23:0] sec);
		logic [7:0] b;
		for (int i = 0; i < n; i++) begin
			host.rd_byte(b);
			check({24'h0, b}, {24'h0, a[7:0] ^ a[23:16]});
			check({28'h0, io_oe}, 32'hF);
			a = (sec == 24'h0) ? a + 24'h1 :
				(a & ~(sec - 24'h1)) | ((a + 24'h1) & (sec - 24'h1));
		end
		host.close();
	endtask : rd_chk
	task automatic wrap_set(input logic [7:0] w);
		host.open();
		host.send({24'h0, qfr_pkg::OP_BURST_WRAP_SETUP}, 8, 1);
		host.send({24'h0, w}, 32, 1);
		host.close();
	endtask : wrap_set
	// read over the top of the array, stopped mid-stream
	task automatic t_qor;
		host.open();
		host.send({24'h0, qfr_pkg::OP_QUAD_OUTPUT_READ}, 8, 1);
		host.send({8'h0, 24'hFFFFFE}, 24, 1);
		host.idle(8);
		rd_chk(24'hFFFFFE, 3, 24'h0);
		check({28'h0, io_oe}, 32'h0);
		check({31'h0, mrdy}, 32'h0);
	endtask : t_qor
	task automatic t_cont;
		qio(24'h123456, 8'hA0, 1'b1, 4);
		rd_chk(24'h123456, 2, 24'h0);
		check({31'h0, cont}, 32'h1);
		qio(24'h00ABCD, 8'h00, 1'b0, 4);
		rd_chk(24'h00ABCD, 2, 24'h0);
		check({31'h0, cont}, 32'h0);
		qio(24'h000040, 8'hA0, 1'b1, 4);
		host.close();
		check({31'h0, cont}, 32'h1);
		cmr = 1'b1;
		@(negedge clk_sys_in);
		cmr = 1'b0;
		repeat (2) @(negedge clk_sys_in);
		check({31'h0, cont}, 32'h0);
		qio(24'h000040, 8'hA0, 1'b1, 0);
		host.close();
		check({31'h0, cont}, 32'h1);
		// all ones on line 0 make the first mode nibble read 0001
		host.open();
		host.send(32'hFF, 8, 1);
		host.close();
		check({31'h0, cont}, 32'h0);
	endtask : t_cont
	// double-rate read with opcode, then a continuation frame
	task automatic t_dtr;
		logic [31:0] am;
		logic [23:0] a;
		logic [3:0] g, hi, lo;
		for (int f = 0; f < 2; f++) begin
			a = (f == 0) ? 24'h3412F0 : 24'h0000FF;
			am = {a, (f == 0) ? 8'hA0 : 8'h00};
			host.open();
			if (f == 0)
				host.send({24'h0,
					qfr_pkg::OP_DOUBLE_RATE_QUAD_IO_READ}, 8, 1);
			for (int i = 0; i < 8; i++)
				host.half(am[28 - 4 * i +: 4], 1'b1, g);
			// four dummy clocks, then the first data fall and its rise
			for (int i = 0; i < 9; i++)
				host.half(4'h0, 1'b0, g);
			// each read shows the nibble of two edges before
			for (int i = 0; i < 2; i++) begin
				host.half(4'h0, 1'b0, hi);
				host.half(4'h0, 1'b0, lo);
				check({24'h0, hi, lo}, {24'h0, a[7:0] ^ a[23:16]});
				a = a + 24'h1;
			end
			host.half(4'h0, 1'b0, g);
			host.close();
			check({31'h0, cont}, (f == 0) ? 32'h1 : 32'h0);
		end
	endtask : t_dtr
	// busy array, then quad enable low: the frame gets no answer
	task automatic t_refuse;
		for (int k = 0; k < 2; k++) begin
			busy = (k == 0);
			qe = (k == 0);
			qio(24'h000020, 8'hA0, 1'b1, 4);
			host.idle(2);
			check({27'h0, cont, io_oe}, 32'h0);
			host.close();
		end
		busy = 1'b0;
		qe = 1'b1;
	endtask : t_refuse
	// every wrap length, read across the section end, then leave wrapping
	task automatic t_wrap;
		logic [23:0] sec;
		for (int k = 0; k < 4; k++) begin
			sec = 24'h8 << k;
			wrap_set({1'b0, 2'(k), 5'h0});
			check({29'h0, wdis, wlen}, 32'(k));
			qio(24'h000100 + sec - 24'h1, 8'h00, 1'b1, 4);
			rd_chk(24'h000100 + sec - 24'h1, 2, sec);
		end
		wrap_set(8'h10);
		check({29'h0, wdis, wlen}, 32'h4);
		qio(24'h000107, 8'h00, 1'b1, 4);
		rd_chk(24'h000107, 2, 24'h0);
	endtask : t_wrap
	// defaults after a reset instruction, then a four-wire read and the dummy field map
	task automatic t_four_wire;
		rst_ins = 1'b1;
		@(negedge clk_sys_in);
		rst_ins = 1'b0;
		repeat (2) @(negedge clk_sys_in);
		check({27'h0, wdis, dclk}, 32'h12);
		wrap_set(8'h00);
		fw = 1'b1;
		qio(24'h000107, 8'h00, 1'b1, 0);
		rd_chk(24'h000107, 2, 24'h0);
		for (int k = 0; k < 4; k++) begin
			rp = 2'(k);
			set_rp = 1'b1;
			@(negedge clk_sys_in);
			set_rp = 1'b0;
			repeat (2) @(negedge clk_sys_in);
			check({28'h0, dclk}, k == 0 ? 32'hA : 32'(2 * k + 2));
		end
		fw = 1'b0;
	endtask : t_four_wire
	// hang guard, far above the few thousand cycles needed
	always @(posedge clk_sys_in) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			conclude();
		end
	end
	initial begin
		repeat (2) @(negedge clk_sys_in);
		rst_n_in = 1'b1;
		repeat (6) @(negedge clk_sys_in);
		check({20'h0, cont, wdis, wlen, dclk, io_oe}, 32'h420);
		t_qor();
		t_cont();
		t_dtr();
		t_refuse();
		t_wrap();
		t_four_wire();
		conclude();
	end
endmodule : tb_qfr_read_engine
